// ===== verilog/sras_defines.svh
`ifndef SRAS_DEFINES_SVH
`define SRAS_DEFINES_SVH

// ****************************************************************
// Serial register access slave constants
// ****************************************************************
// Slave address value is arbitrary
`define SRAS_SLAVE_ADDR   7'h2D
`define SRAS_FIFO_DEPTH   8
`define SRAS_BITS_BYTE    4'h8
`define SRAS_DET_WAIT     2'h3
`define SRAS_PTR_RESET    8'h00
`define SRAS_SYNC_RESET   3'h7

`endif

// ===== verilog/sras_pkg.sv
package sras_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_DEVADDR   = 4'h1,
        ST_ACK_ADDR  = 4'h3,
        ST_PTR       = 4'h2,
        ST_ACK_PTR   = 4'h6,
        ST_WDATA     = 4'h7,
        ST_ACK_WDATA = 4'h5,
        ST_RDATA     = 4'h4,
        ST_MACK      = 4'hC
    } sras_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } sras_wr_t;

endpackage : sras_pkg

// ===== verilog/sras_top.sv
// Functional notes
// R1: Byte after address write loads the pointer
// R2: Written bytes stored at pointer, acked, pointer advances; a byte that finds the FIFO full is NACKed instead and the slave idles
// R3: Write burst continues until Stop is seen
// R4: Host sets pointer by write before reading
// R5: Reads return pointer register, then pointer advances
// R6: Host NACKs the last byte it wants
// R7: Read opens with Start or Repeated Start
// R8: Port enabled only when both lines pulled high
// R9: After NACK, release data and idle
`include "sras_defines.svh"

// ****************************************************************
// Write event FIFO
// ****************************************************************
module sras_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [0:DEPTH-1];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic [AW:0]  wr_ptr_nxt;
    logic [AW:0]  rd_ptr_nxt;

    always_comb begin
        in_ready   = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH);
        out_valid  = wr_ptr_r != rd_ptr_r;
        out_data   = mem_r[rd_ptr_r[AW-1:0]];
        wr_ptr_nxt = wr_ptr_r + (AW + 1)'(in_valid && in_ready);
        rd_ptr_nxt = rd_ptr_r + (AW + 1)'(out_valid && out_ready);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end
endmodule : sras_fifo

// ****************************************************************
// Serial register access slave
// ****************************************************************
module sras_top #(
    parameter logic [6:0] SLAVE_ADDR = `SRAS_SLAVE_ADDR,
    parameter int         FIFO_DEPTH = `SRAS_FIFO_DEPTH
) (
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    output logic                   SDA_OUT,
    output logic                   SDA_OE,
    output logic                   PORT_EN,
    output logic                   WR_VALID,
    output sras_pkg::sras_wr_t     WR_EVT,
    input  wire logic              WR_READY
);
    // ****************************************************************
    // Pin synchronisers and bus condition detection
    // ****************************************************************
    logic [2:0] scl_sh_r;
    logic [2:0] sda_sh_r;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            scl_sh_r <= `SRAS_SYNC_RESET;
            sda_sh_r <= `SRAS_SYNC_RESET;
        end else begin
            scl_sh_r <= {scl_sh_r[1:0], SCL_IN};
            sda_sh_r <= {sda_sh_r[1:0], SDA_IN};
        end
    end

    always_comb begin
        scl_s     = scl_sh_r[1];
        sda_s     = sda_sh_r[1];
        scl_rise  = scl_s && !scl_sh_r[2];
        scl_fall  = !scl_s && scl_sh_r[2];
        start_det = scl_s && scl_sh_r[2] && sda_sh_r[2] && !sda_s;
        stop_det  = scl_s && scl_sh_r[2] && !sda_sh_r[2] && sda_s;
    end

    // ****************************************************************
    // Port detection
    // ****************************************************************
    // Lines are judged once, after the synchronisers have settled
    logic [1:0] det_cnt_r;
    logic [1:0] det_cnt_nxt;
    logic       port_en_r;
    logic       port_en_nxt;

    always_comb begin
        det_cnt_nxt = det_cnt_r;
        port_en_nxt = port_en_r;
        if (det_cnt_r != `SRAS_DET_WAIT) begin
            det_cnt_nxt = det_cnt_r + 2'h1;
            if (det_cnt_nxt == `SRAS_DET_WAIT) begin
                port_en_nxt = scl_s && sda_s; // [R8]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            det_cnt_r <= 2'h0;
            port_en_r <= 1'b0;
        end else begin
            det_cnt_r <= det_cnt_nxt;
            port_en_r <= port_en_nxt;
        end
    end

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    sras_pkg::sras_state_t state_r;
    sras_pkg::sras_state_t state_nxt;
    logic [3:0]            cnt_r;
    logic [3:0]            cnt_nxt;
    logic [7:0]            shift_r;
    logic [7:0]            shift_nxt;
    logic [7:0]            tx_r;
    logic [7:0]            tx_nxt;
    logic [7:0]            ptr_r;
    logic [7:0]            ptr_nxt;
    logic                  rw_r;
    logic                  rw_nxt;
    logic                  oe_r;
    logic                  oe_nxt;
    logic                  mem_we;
    logic [7:0]            regs_r [0:255];
    logic [7:0]            rd_byte;
    logic                  fifo_in_ready;
    logic                  push;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        oe_nxt    = oe_r;
        mem_we    = 1'b0;
        push      = 1'b0;
        rd_byte   = regs_r[ptr_r];
        if (!port_en_r) begin
            state_nxt = sras_pkg::ST_IDLE; // [R8]
            oe_nxt    = 1'b0;
        end else if (start_det) begin
            // Fresh Start and Repeated Start are handled alike
            state_nxt = sras_pkg::ST_DEVADDR; // [R7]
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
        end else if (stop_det) begin
            state_nxt = sras_pkg::ST_IDLE; // [R3]
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                sras_pkg::ST_DEVADDR, sras_pkg::ST_PTR, sras_pkg::ST_WDATA: begin
                    if (scl_rise && cnt_r != `SRAS_BITS_BYTE) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == `SRAS_BITS_BYTE) begin
                        cnt_nxt = 4'h0;
                        if (state_r == sras_pkg::ST_DEVADDR) begin
                            if (shift_r[7:1] == SLAVE_ADDR) begin
                                rw_nxt    = shift_r[0];
                                oe_nxt    = 1'b1;
                                state_nxt = sras_pkg::ST_ACK_ADDR;
                            end else begin
                                state_nxt = sras_pkg::ST_IDLE;
                            end
                        end else if (state_r == sras_pkg::ST_PTR) begin
                            ptr_nxt   = shift_r; // [R1]
                            oe_nxt    = 1'b1;
                            state_nxt = sras_pkg::ST_ACK_PTR;
                        end else if (fifo_in_ready) begin
                            // A full FIFO NACKs the byte so nothing is lost
                            mem_we    = 1'b1; // [R2]
                            push      = 1'b1;
                            ptr_nxt   = ptr_r + 8'h01; // [R2]
                            oe_nxt    = 1'b1;
                            state_nxt = sras_pkg::ST_ACK_WDATA;
                        end else begin
                            state_nxt = sras_pkg::ST_IDLE;
                        end
                    end
                end
                sras_pkg::ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin
                            tx_nxt    = rd_byte; // [R5]
                            ptr_nxt   = ptr_r + 8'h01; // [R5]
                            oe_nxt    = !rd_byte[7];
                            state_nxt = sras_pkg::ST_RDATA;
                        end else begin
                            oe_nxt    = 1'b0;
                            state_nxt = sras_pkg::ST_PTR;
                        end
                    end
                end
                sras_pkg::ST_ACK_PTR, sras_pkg::ST_ACK_WDATA: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = sras_pkg::ST_WDATA; // [R3]
                    end
                end
                sras_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == `SRAS_BITS_BYTE) begin
                            oe_nxt    = 1'b0;
                            state_nxt = sras_pkg::ST_MACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = !tx_r[6];
                        end
                    end
                end
                sras_pkg::ST_MACK: begin
                    if (scl_rise && sda_s) begin
                        state_nxt = sras_pkg::ST_IDLE; // [R9]
                    end else if (scl_fall) begin
                        cnt_nxt   = 4'h0;
                        tx_nxt    = rd_byte; // [R5]
                        ptr_nxt   = ptr_r + 8'h01; // [R5]
                        oe_nxt    = !rd_byte[7];
                        state_nxt = sras_pkg::ST_RDATA;
                    end
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= sras_pkg::ST_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= `SRAS_PTR_RESET;
            rw_r    <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // Register space has no reset; contents are undefined until written
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            regs_r[ptr_r] <= shift_r;
        end
    end

    // ****************************************************************
    // Write event path to the core
    // ****************************************************************
    sras_pkg::sras_wr_t fifo_out;
    sras_pkg::sras_wr_t evt_r;
    sras_pkg::sras_wr_t evt_nxt;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic               out_valid_r;
    logic               out_valid_nxt;

    sras_fifo #(
        .W     (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({ptr_r, shift_r}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    always_comb begin
        fifo_out_ready = !out_valid_r || WR_READY;
        out_valid_nxt  = out_valid_r;
        evt_nxt        = evt_r;
        if (fifo_out_ready) begin
            out_valid_nxt = fifo_out_valid;
            evt_nxt       = fifo_out;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            out_valid_r <= 1'b0;
            evt_r       <= '0;
        end else begin
            out_valid_r <= out_valid_nxt;
            evt_r       <= evt_nxt;
        end
    end

    always_comb begin
        SDA_OUT  = 1'b0;
        SDA_OE   = oe_r;
        PORT_EN  = port_en_r;
        WR_VALID = out_valid_r;
        WR_EVT   = evt_r;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_byte_acked;
        state_r == sras_pkg::ST_MACK && scl_fall && !start_det && !stop_det && port_en_r;
    endsequence

    sequence s_next_byte_loaded;
        state_r == sras_pkg::ST_RDATA && cnt_r == 4'h0;
    endsequence

    property p_ptr_load;
        (state_r == sras_pkg::ST_PTR && scl_fall && cnt_r == `SRAS_BITS_BYTE && !start_det && !stop_det
            && port_en_r) |=> (ptr_r == $past(shift_r) && oe_r && state_r == sras_pkg::ST_ACK_PTR);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // [R1]

    property p_write_store;
        (state_r == sras_pkg::ST_WDATA && scl_fall && cnt_r == `SRAS_BITS_BYTE && fifo_in_ready
            && !start_det && !stop_det && port_en_r)
            |=> (ptr_r == $past(ptr_r) + 8'h01 && oe_r) ##1 regs_r[$past(ptr_r, 2)] == $past(shift_r, 2);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write byte not stored"); // [R2]

    property p_burst_hold;
        (state_r == sras_pkg::ST_ACK_WDATA && scl_fall && !start_det && !stop_det && port_en_r)
            |=> state_r == sras_pkg::ST_WDATA && !oe_r;
    endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("write burst ended without stop"); // [R3]

    property p_read_advance;
        s_byte_acked |=> s_next_byte_loaded and (ptr_r == $past(ptr_r) + 8'h01);
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read pointer not advanced"); // [R5]

    property p_start_any;
        (start_det && port_en_r) |=> state_r == sras_pkg::ST_DEVADDR && !oe_r;
    endproperty
    a_start_any: assert property (p_start_any) else $error("start not accepted"); // [R7]

    property p_port_off;
        !port_en_r |=> state_r == sras_pkg::ST_IDLE && !SDA_OE;
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port active"); // [R8]

    property p_nack_idle;
        (state_r == sras_pkg::ST_MACK && scl_rise && sda_s && !start_det && !stop_det && port_en_r)
            |=> (state_r == sras_pkg::ST_IDLE && !oe_r && $stable(ptr_r)) [*2];
    endproperty
    a_nack_idle: assert property (p_nack_idle) else $error("no release after nack"); // [R9]

endmodule : sras_top

// ===== tb/sras_host_model.sv
// ****************************************************************
// Two-wire bus host: drives the clock line, releases data as 1
// ****************************************************************
module sras_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each phase well over the 3 cycles the slave needs to see an edge
    localparam int HALF = 6;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick();
        repeat (HALF) @(posedge clk);
    endtask : tick

    // Serves as Start from idle and as Repeated Start after a bit
    task automatic start();
        tick();
        sda_o <= 1'b1;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_o <= 1'b0;
        tick();
        scl_o <= 1'b0;
    endtask : start

    task automatic stop();
        tick();
        sda_o <= 1'b0;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_o <= 1'b1;
        tick();
    endtask : stop

    task automatic bit_xfer(input logic b, output logic s);
        tick();
        sda_o <= b;
        tick();
        scl_o <= 1'b1;
        tick();
        s = sda_line;
        scl_o <= 1'b0;
    endtask : bit_xfer

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : wbyte

    // Last wanted byte is answered with a NACK
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(nack, s);
    endtask : rbyte
endmodule : sras_host_model

// ===== tb/serial_register_access_slave_test.sv
module serial_register_access_slave_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Slave address value is arbitrary
    localparam logic [6:0] SADDR = 7'h2D;

    logic                    clk = 1'b0;
    logic                    sys_rst = 1'b1;
    logic                    sda_pd = 1'b1;
    logic                    wr_ready = 1'b0;
    logic                    hold_rdy = 1'b0;
    logic                    scl_o;
    logic                    sda_o;
    logic                    sda_out;
    logic                    sda_oe;
    logic                    port_en;
    logic                    wr_valid;
    sras_pkg::sras_wr_t      wr_evt;
    sras_pkg::sras_wr_t      exp_q[$];
    logic [7:0]              mem[256];
    int                      err_total = 0;
    int                      check_count = 0;
    int                      seed = 32'he564_f01e;
    int                      acc;
    wire                     sda_line = ~sda_pd & sda_o & ~sda_oe;

    always #4 clk = ~clk;

    sras_top #(.SLAVE_ADDR(SADDR)) dut (
        .CLK      (clk),
        .SYS_RST  (sys_rst),
        .SCL_IN   (scl_o),
        .SDA_IN   (sda_line),
        .SDA_OUT  (sda_out),
        .SDA_OE   (sda_oe),
        .PORT_EN  (port_en),
        .WR_VALID (wr_valid),
        .WR_EVT   (wr_evt),
        .WR_READY (wr_ready)
    );

    sras_host_model host (
        .clk      (clk),
        .sda_line (sda_line),
        .scl_o    (scl_o),
        .sda_o    (sda_o)
    );

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Random stalls on the event side; held low while filling the FIFO
    always @(posedge clk) begin
        wr_ready <= ~hold_rdy & 1'($random(seed));
    end

    always @(posedge clk) begin
        if (!sys_rst && wr_valid === 1'b1 && wr_ready) begin
            if (exp_q.size() == 0) begin
                check(wr_evt, 16'hxxxx);
            end else begin
                check(wr_evt, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    // ****************************************************************
    // Bus sequences
    // ****************************************************************
    task automatic wr_seq(input logic [7:0] p, input int n, output int ok);
        logic       a;
        logic [7:0] d;
        ok = 0;
        host.start();
        host.wbyte({SADDR, 1'b0}, a);
        check(a, 1'b1);
        host.wbyte(p, a);
        check(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            // Noted before the byte goes out: its event can reach the port before the ack bit ends
            exp_q.push_back({8'(p + k), d});
            host.wbyte(d, a);
            if (!a) begin
                // A refused byte never reaches the port, so its note is withdrawn
                void'(exp_q.pop_back());
                break;
            end
            mem[8'(p + k)] = d;
            ok++;
        end
        host.stop();
    endtask : wr_seq

    task automatic rd_seq(input logic setp, input logic rep, input logic [7:0] p, input int n);
        logic       a;
        logic [7:0] d;
        if (setp) begin
            host.start();
            host.wbyte({SADDR, 1'b0}, a);
            host.wbyte(p, a);
            if (!rep) begin
                host.stop();
            end
        end
        host.start();
        host.wbyte({SADDR, 1'b1}, a);
        check(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            host.rbyte(k == n - 1, d);
            check(d, mem[8'(p + k)]);
        end
        repeat (8) @(posedge clk);
        check(sda_oe, 1'b0);
        host.stop();
    endtask : rd_seq

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic a;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        check(port_en, 1'b0);
        sys_rst <= 1'b1;
        sda_pd <= 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        check(port_en, 1'b1);
        check(sda_out, 1'b0);
        // Burst across the pointer wrap
        wr_seq(8'hFD, 5, acc);
        check(acc, 5);
        rd_seq(1'b1, 1'b1, 8'hFD, 5);
        rd_seq(1'b1, 1'b0, 8'hFE, 1);
        // No pointer write: continues one past the NACKed byte
        rd_seq(1'b0, 1'b0, 8'hFF, 2);
        host.start();
        host.wbyte({SADDR ^ 7'h01, 1'b0}, a);
        check(a, 1'b0);
        host.stop();
        // Fill the FIFO until a byte is refused, then drain
        hold_rdy <= 1'b1;
        wr_seq(8'h40, 12, acc);
        check(acc < 12, 1'b1);
        hold_rdy <= 1'b0;
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        check(exp_q.size(), 16'h0000);
        rd_seq(1'b1, 1'b0, 8'h40, acc);
        print_verdict();
    end
endmodule : serial_register_access_slave_test
